// ==== design/ofd_pkg.sv ====
// constants and types for the operand field decoder
// assumes one 250 MHz clock; registers reached over AXI4-Lite
package ofd_pkg;
  // instruction cycle: four clock periods per cycle
  localparam logic [1:0] Q_LAST = 2'h3;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TPTR = 8'h04;
  localparam logic [7:0] ADR_TLAT = 8'h08;
  localparam logic [7:0] ADR_IPTR = 8'h0c;
  localparam logic [7:0] ADR_STAT = 8'h10;
  // control fields and reset value
  localparam int CTRL_EN_BIT = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_010f;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [20:0] TPTR_RST = 21'h00_0000;
  localparam logic [7:0] TLAT_RST = 8'h00;
  localparam logic [11:0] IPTR_RST = 12'h000;
  // fixed access region: low half bank 0, high half top bank
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  // tag carried in the top nibble of every second word
  localparam logic [3:0] SECOND_TAG = 4'hf;
  // table pointer treatments
  localparam logic [1:0] TM_NONE = 2'h0;
  localparam logic [1:0] TM_POSTINC = 2'h1;
  localparam logic [1:0] TM_POSTDEC = 2'h2;
  localparam logic [1:0] TM_PREINC = 2'h3;
  // literal widths
  localparam logic [1:0] LW_NONE = 2'h0;
  localparam logic [1:0] LW_8 = 2'h1;
  localparam logic [1:0] LW_12 = 2'h2;
  localparam logic [1:0] LW_20 = 2'h3;
  // instruction cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // instruction forms
  typedef enum logic [3:0] {
    F_NOP, F_ORPHAN, F_BYTE, F_BIT, F_LIT, F_MOVFF, F_LDPTR,
    F_IDX_SF, F_IDX_SS, F_GOTO, F_CALL, F_BRA, F_BCOND, F_RET, F_TBL
  } ofd_form_t;
  // word position within a double-word instruction
  typedef enum logic {ST_FIRST, ST_SECOND} ofd_state_t;
endpackage

// ==== design/ofd_decoder.sv ====
// operand field decoder: splits 16-bit instruction words into fields
// assumes fetch presents words synchronous to clk, held for a cycle
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - access bit 0: fixed access region, bank ignored
// - access bit 1: bank from bank select reg
// - destination bit 0 accumulator, 1 file register
// - three-bit field picks bit 0..7
// - file field 8-bit; pointer designator 2-bit
// - register move: two full 12-bit addresses
// - fast bit 1 uses shadow registers
// - table mode: none, post-inc, post-dec, pre-inc
// - 21-bit table pointer, 8-bit table latch
// - don't-care bits ignored; tools emit zero
// - seven-bit offsets added to index pointer
// - relative branches signed; short calls, long calls and gotos absolute two-word
// - literals of 8, 12 or 20 bits
// - lone second word executes as no-operation
// - instruction cycle is four clock periods
module ofd_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fetched instruction word
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  // program memory answer for table reads
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_rdata_valid,
  // decoded controls
  output var logic dec_valid_r,
  output var ofd_pkg::ofd_form_t dec_form_r,
  output var logic [11:0] dec_src_addr_r,
  output var logic [11:0] dec_dst_addr_r,
  output var logic dec_dest_file_r,
  output var logic [7:0] dec_bit_mask_r,
  output var logic [1:0] dec_ptr_sel_r,
  output var logic [19:0] dec_literal_r,
  output var logic [1:0] dec_lit_width_r,
  output var logic [19:0] dec_target_r,
  output var logic dec_branch_rel_r,
  output var logic dec_fast_r,
  output var logic [1:0] dec_cycles_r,
  output var logic dec_may_skip_r,
  // table access to program memory
  output var logic [20:0] tbl_addr_r,
  output var logic tbl_rd_r,
  output var logic tbl_wr_r,
  output var logic [7:0] tbl_wdata_r,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  // unsigned seven-bit offset onto the index pointer
  function automatic logic [11:0] idx_addr(input logic [11:0] base,
      input logic [6:0] ofs);
    return base + {5'h00, ofs};
  endfunction

  // form of a first word; unlisted codes fall to no-operation
  function automatic ofd_pkg::ofd_form_t form_of(input logic [15:0] w);
    ofd_pkg::ofd_form_t f;
    f = ofd_pkg::F_NOP;
    if (w[15:12] == ofd_pkg::SECOND_TAG) begin
      f = ofd_pkg::F_ORPHAN;
    end else if (w[15:12] == 4'hc) begin
      f = ofd_pkg::F_MOVFF;
    end else if (w[15:11] == 5'h1a) begin
      f = ofd_pkg::F_BRA;
    end else if (w[15:11] == 5'h1b) begin
      f = ofd_pkg::F_CALL;
    end else if (w[15:11] == 5'h1c) begin
      f = ofd_pkg::F_BCOND;
    end else if (w[15:9] == 7'h76) begin
      f = ofd_pkg::F_CALL;
    end else if (w[15:8] == 8'hef) begin
      f = ofd_pkg::F_GOTO;
    end else if (w[15:6] == 10'h3b8) begin
      f = ofd_pkg::F_LDPTR;
    end else if (w[15:8] == 8'heb) begin
      f = w[7] ? ofd_pkg::F_IDX_SS : ofd_pkg::F_IDX_SF;
    end else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hb) begin
      f = ofd_pkg::F_BIT;
    end else if (w[15:12] != 4'h0 && w[15:12] <= 4'h6) begin
      f = ofd_pkg::F_BYTE;
    end else if (w[15:12] == 4'h0 && (w[11] || w[11:8] == 4'h1)) begin
      f = ofd_pkg::F_LIT;
    end else if (w[15:8] == 8'h00 && w[7:4] == 4'h0 && w[3]) begin
      f = ofd_pkg::F_TBL;
    end else if (w[15:8] == 8'h00 && w[7:2] == 6'h04) begin
      f = ofd_pkg::F_RET;
    end else if (w[15:12] == 4'h0 && w[11:10] != 2'h0) begin
      f = ofd_pkg::F_BYTE;
    end else if (w[15:12] == 4'h0 && w[11:9] == 3'h1) begin
      f = ofd_pkg::F_BYTE;
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // instruction cycle divider

  logic [1:0] q_r; // clock phase within the cycle
  wire cyc_en = (q_r == ofd_pkg::Q_LAST);

  // four clocks per instruction cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] ctrl_r; // bank select and decode enable
  logic [20:0] table_pointer_r;
  logic [7:0] table_latch_r;
  logic [11:0] iptr_r; // index pointer for offset forms
  ofd_pkg::ofd_state_t state_r;
  logic [15:0] first_r; // held first word of a pair
  logic pair_err_r; // second word lacked its tag

  wire [3:0] bank_select_reg = ctrl_r[3:0];
  wire dec_en = ctrl_r[ofd_pkg::CTRL_EN_BIT];

  ////////////////////////////////////////////////////////////////////
  // field extraction, all combinational from the word

  wire in_second = (state_r == ofd_pkg::ST_SECOND);
  wire [15:0] fw = in_second ? first_r : instr_word; // first word
  wire [15:0] sw = instr_word; // second word when paired
  wire ofd_pkg::ofd_form_t form = form_of(fw);
  wire two_word = form inside {ofd_pkg::F_MOVFF, ofd_pkg::F_LDPTR,
      ofd_pkg::F_IDX_SF, ofd_pkg::F_IDX_SS, ofd_pkg::F_GOTO} ||
      (form == ofd_pkg::F_CALL && fw[11]);
  wire take = cyc_en && instr_valid && dec_en;
  wire take_first = take && !in_second;
  wire take_second = take && in_second;
  wire done = take && (in_second || !two_word);

  // bank addressing
  wire [3:0] acc_bank = fw[7] ? ofd_pkg::ACC_HI_BANK : ofd_pkg::ACC_LO_BANK;
  wire [11:0] acc_addr = {acc_bank, fw[7:0]};
  wire [11:0] bank_addr = {bank_select_reg, fw[7:0]};
  wire [11:0] ram_addr = fw[8] ? bank_addr : acc_addr;

  // bit position one-hot
  wire [7:0] bit_mask = 8'h01 << fw[11:9];

  // full-range move and indexed addresses
  wire [11:0] src_addr =
      (form == ofd_pkg::F_MOVFF) ? fw[11:0] :
      (form inside {ofd_pkg::F_IDX_SF, ofd_pkg::F_IDX_SS}) ?
      idx_addr(iptr_r, fw[6:0]) : ram_addr;
  // movss second word: only low seven bits count
  wire [11:0] dst_addr =
      (form inside {ofd_pkg::F_MOVFF, ofd_pkg::F_IDX_SF}) ? sw[11:0] :
      (form == ofd_pkg::F_IDX_SS) ? idx_addr(iptr_r, sw[6:0]) :
      ram_addr;

  // literal widths per form
  wire [19:0] literal =
      (form == ofd_pkg::F_LIT) ? {12'h000, fw[7:0]} :
      (form == ofd_pkg::F_LDPTR) ? {8'h00, fw[3:0], sw[7:0]} :
      (form inside {ofd_pkg::F_GOTO, ofd_pkg::F_CALL}) ?
      {sw[11:0], fw[7:0]} : 20'h00000;
  wire [1:0] lit_width =
      (form == ofd_pkg::F_LIT) ? ofd_pkg::LW_8 :
      (form == ofd_pkg::F_LDPTR) ? ofd_pkg::LW_12 :
      (form inside {ofd_pkg::F_GOTO, ofd_pkg::F_CALL}) ? ofd_pkg::LW_20 :
      ofd_pkg::LW_NONE;

  // eleven-bit relative field used by F_BRA only; both call codes have fw[11] set
  wire rel11 = (form == ofd_pkg::F_BRA) ||
      (form == ofd_pkg::F_CALL && !fw[11]);
  wire [19:0] target =
      rel11 ? {{9{fw[10]}}, fw[10:0]} :
      (form == ofd_pkg::F_BCOND) ? {{12{fw[7]}}, fw[7:0]} :
      literal;
  wire branch_rel = rel11 || (form == ofd_pkg::F_BCOND);

  // shadow select
  wire fast = (form == ofd_pkg::F_CALL && fw[11]) ? fw[8] :
      (form == ofd_pkg::F_RET) ? fw[0] : 1'b0;

  // cycle count: two when the pc always moves or for pairs
  wire pc_moves = branch_rel && (form != ofd_pkg::F_BCOND);
  wire [1:0] cycles = (two_word || pc_moves || form == ofd_pkg::F_RET) ?
      ofd_pkg::CYC_TWO : ofd_pkg::CYC_ONE;
  wire may_skip = (form == ofd_pkg::F_BCOND) ||
      (form == ofd_pkg::F_BIT && fw[15:13] == 3'h5);

  ////////////////////////////////////////////////////////////////////
  // table access

  wire [1:0] table_update_mode = fw[1:0];
  wire tbl_go = done && (form == ofd_pkg::F_TBL);
  wire [20:0] tp_inc = table_pointer_r + 21'h000001;
  wire [20:0] tp_dec = table_pointer_r - 21'h000001;
  wire [20:0] tp_upd =
      (table_update_mode == ofd_pkg::TM_NONE) ? table_pointer_r :
      (table_update_mode == ofd_pkg::TM_POSTDEC) ? tp_dec : tp_inc;
  wire [20:0] tp_use =
      (table_update_mode == ofd_pkg::TM_PREINC) ? tp_inc :
      table_pointer_r;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = wr_go && awaddr_r == ofd_pkg::ADR_CTRL;
  wire wr_tptr = wr_go && awaddr_r == ofd_pkg::ADR_TPTR;
  wire wr_tlat = wr_go && awaddr_r == ofd_pkg::ADR_TLAT;
  wire wr_iptr = wr_go && awaddr_r == ofd_pkg::ADR_IPTR;
  wire wr_hit = wr_ctrl || wr_tptr || wr_tlat || wr_iptr ||
      awaddr_r == ofd_pkg::ADR_STAT;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  wire [31:0] stat_word = {24'h000000, pair_err_r, state_r,
      1'b0, dec_form_r, dec_valid_r};
  wire rd_hit = s_axi_araddr inside {ofd_pkg::ADR_CTRL,
      ofd_pkg::ADR_TPTR, ofd_pkg::ADR_TLAT, ofd_pkg::ADR_IPTR,
      ofd_pkg::ADR_STAT};
  wire [31:0] rd_word =
      (s_axi_araddr == ofd_pkg::ADR_CTRL) ? ctrl_r :
      (s_axi_araddr == ofd_pkg::ADR_TPTR) ? {11'h000, table_pointer_r} :
      (s_axi_araddr == ofd_pkg::ADR_TLAT) ? {24'h000000, table_latch_r} :
      (s_axi_araddr == ofd_pkg::ADR_IPTR) ? {20'h00000, iptr_r} :
      (s_axi_araddr == ofd_pkg::ADR_STAT) ? stat_word : 32'h00000000;
  wire [31:0] wmerge_ctrl = merge(ctrl_r, wdata_r, wstrb_r);
  wire [31:0] wmerge_tptr = merge({11'h000, table_pointer_r}, wdata_r,
      wstrb_r);
  wire [31:0] wmerge_tlat = merge({24'h000000, table_latch_r}, wdata_r,
      wstrb_r);
  wire [31:0] wmerge_iptr = merge({20'h00000, iptr_r}, wdata_r, wstrb_r);

  // software writes win over the hardware pointer update
  wire [20:0] table_pointer_nxt = wr_tptr ? wmerge_tptr[20:0] :
      tbl_go ? tp_upd : table_pointer_r;
  wire [7:0] table_latch_nxt = wr_tlat ? wmerge_tlat[7:0] :
      tbl_rdata_valid ? tbl_rdata : table_latch_r;

  ////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ofd_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // reopen both channels once the answer is taken
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one read at a time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ofd_pkg::RESP_OKAY;
    end else if (ar_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software-visible state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r <= ofd_pkg::CTRL_RST;
      table_pointer_r <= ofd_pkg::TPTR_RST;
      table_latch_r <= ofd_pkg::TLAT_RST;
      iptr_r <= ofd_pkg::IPTR_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wmerge_ctrl & ofd_pkg::CTRL_MASK;
      end
      if (wr_iptr) begin
        iptr_r <= wmerge_iptr[11:0];
      end
      table_pointer_r <= table_pointer_nxt;
      table_latch_r <= table_latch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // word pairing

  // a lone tagged word decodes as no-operation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ofd_pkg::ST_FIRST;
      first_r <= 16'h0000;
      pair_err_r <= 1'b0;
    end else if (take_first && two_word) begin
      state_r <= ofd_pkg::ST_SECOND;
      first_r <= instr_word;
    end else if (take_second) begin
      state_r <= ofd_pkg::ST_FIRST;
      pair_err_r <= (instr_word[15:12] != ofd_pkg::SECOND_TAG);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoded controls, updated once per instruction cycle

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dec_valid_r <= 1'b0;
      dec_form_r <= ofd_pkg::F_NOP;
      dec_src_addr_r <= 12'h000;
      dec_dst_addr_r <= 12'h000;
      dec_dest_file_r <= 1'b0;
      dec_bit_mask_r <= 8'h01;
      dec_ptr_sel_r <= 2'h0;
      dec_literal_r <= 20'h00000;
      dec_lit_width_r <= ofd_pkg::LW_NONE;
      dec_target_r <= 20'h00000;
      dec_branch_rel_r <= 1'b0;
      dec_fast_r <= 1'b0;
      dec_cycles_r <= ofd_pkg::CYC_ONE;
      dec_may_skip_r <= 1'b0;
    end else begin
      dec_valid_r <= done;
      if (done) begin
        dec_form_r <= form;
        dec_src_addr_r <= src_addr;
        dec_dst_addr_r <= dst_addr;
        dec_dest_file_r <= fw[9];
        dec_bit_mask_r <= bit_mask;
        dec_ptr_sel_r <= fw[5:4];
        dec_literal_r <= literal;
        dec_lit_width_r <= lit_width;
        dec_target_r <= target;
        dec_branch_rel_r <= branch_rel;
        dec_fast_r <= fast;
        dec_cycles_r <= cycles;
        dec_may_skip_r <= may_skip;
      end
    end
  end

  // program memory strobes for table reads and writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tbl_addr_r <= 21'h000000;
      tbl_rd_r <= 1'b0;
      tbl_wr_r <= 1'b0;
      tbl_wdata_r <= 8'h00;
    end else begin
      tbl_rd_r <= tbl_go && !fw[2];
      tbl_wr_r <= tbl_go && fw[2];
      if (tbl_go) begin
        tbl_addr_r <= tp_use;
        tbl_wdata_r <= table_latch_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_quiet3;
    !cyc_en [*3];
  endsequence

  a_cycle_four_clk: assert property (@(posedge clk) disable iff (!rst_n)
    cyc_en |=> s_quiet3 ##1 cyc_en)
    else $error("instruction cycle not four clocks");

  a_access_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (take_first && form == ofd_pkg::F_BYTE && !instr_word[8]) |=>
    dec_src_addr_r[11:8] ==
    ($past(instr_word[7]) ? ofd_pkg::ACC_HI_BANK : ofd_pkg::ACC_LO_BANK))
    else $error("access region address wrong");

  a_bank_select: assert property (@(posedge clk) disable iff (!rst_n)
    (take_first && form == ofd_pkg::F_BIT && instr_word[8]) |=>
    dec_src_addr_r == {$past(bank_select_reg), $past(instr_word[7:0])})
    else $error("banked address wrong");

  a_dest_route: assert property (@(posedge clk) disable iff (!rst_n)
    (take_first && form == ofd_pkg::F_BYTE) |=>
    dec_valid_r && dec_dest_file_r == $past(instr_word[9]))
    else $error("destination select wrong");

  a_bit_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(dec_bit_mask_r))
    else $error("bit mask not one-hot");

  a_lone_second: assert property (@(posedge clk) disable iff (!rst_n)
    (take_first && instr_word[15:12] == ofd_pkg::SECOND_TAG) |=>
    dec_form_r == ofd_pkg::F_ORPHAN && state_r == ofd_pkg::ST_FIRST)
    else $error("lone second word not a no-operation");

  a_move_pair: assert property (@(posedge clk) disable iff (!rst_n)
    (take_second && form == ofd_pkg::F_MOVFF) |=>
    dec_dst_addr_r == $past(instr_word[11:0]) &&
    dec_src_addr_r == $past(first_r[11:0]))
    else $error("register move addresses wrong");

  a_once_per_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    dec_valid_r |-> $past(cyc_en) ##1 !dec_valid_r [*3])
    else $error("decode not once per cycle");

  a_tbl_postinc: assert property (@(posedge clk) disable iff (!rst_n)
    (tbl_go && table_update_mode == ofd_pkg::TM_POSTINC && !wr_tptr) |=>
    table_pointer_r == $past(table_pointer_r) + 21'h000001 &&
    tbl_addr_r == $past(table_pointer_r))
    else $error("post-increment wrong");

  a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");

endmodule

`default_nettype wire

// ==== sim/ofd_fetch_model.sv ====
// fetch stage and program memory stand-in for the operand decoder
// assumes the decoder takes a word on every fourth clock after reset
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // word feed
  output var logic [15:0] instr_word,
  output var logic instr_valid,
  // table read answer
  input wire logic [20:0] tbl_addr_r,
  input wire logic tbl_rd_r,
  output var logic [7:0] tbl_rdata,
  output var logic tbl_rdata_valid
);
  logic [15:0] wq[$]; // words waiting to be fetched
  logic [1:0] q_r = 2'h0; // phase, mirrors the decoder's count
  initial begin
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    tbl_rdata = 8'h00;
    tbl_rdata_valid = 1'b0;
  end
  // words are queued whole, pairs back to back
  task automatic push(input logic [15:0] w);
    wq.push_back(w);
  endtask
  //////////////////////////////////////////////////////////////////
  // one word per four-clock cycle; idle bus shows a changed value
  always @(posedge clk) begin
    q_r <= rst_n ? q_r + 2'h1 : 2'h0;
    if (!rst_n) begin
      instr_valid <= 1'b0;
    end else if (!instr_valid || q_r == ofd_pkg::Q_LAST) begin
      if (wq.size() > 0) begin
        instr_word <= wq.pop_front();
        instr_valid <= 1'b1;
      end else begin
        instr_word <= ~instr_word;
        instr_valid <= 1'b0;
      end
    end
    // byte answer derived from the address, one clock after the strobe
    tbl_rdata_valid <= tbl_rd_r;
    tbl_rdata <= tbl_rd_r ? (tbl_addr_r[7:0] ^ 8'ha5) : ~tbl_rdata;
  end
endmodule
`default_nettype wire

// ==== sim/operand_field_decoder_test.sv ====
// self-checking bench for the operand field decoder
// assumes the fetch model in ofd_fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module operand_field_decoder_test;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [15:0] instr_word;
  logic instr_valid, tbl_rdata_valid, dec_valid_r, dec_dest_file_r, dec_branch_rel_r;
  logic [7:0] tbl_rdata, dec_bit_mask_r, s_axi_awaddr, s_axi_araddr;
  ofd_pkg::ofd_form_t dec_form_r;
  logic [11:0] dec_src_addr_r, dec_dst_addr_r;
  logic [1:0] dec_ptr_sel_r, dec_lit_width_r, dec_cycles_r, s_axi_bresp, s_axi_rresp;
  logic [19:0] dec_literal_r, dec_target_r;
  logic dec_fast_r, tbl_rd_r, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [20:0] tbl_addr_r;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic dec_may_skip_r, tbl_wr_r;
  logic [7:0] tbl_wdata_r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares = 0, num_checks = 0;
  always #2 clk = ~clk; // 250 MHz
  ofd_decoder ofd_decoder_i (.clk, .rst_n, .instr_word, .instr_valid, .tbl_rdata,
    .tbl_rdata_valid, .dec_valid_r, .dec_form_r, .dec_src_addr_r, .dec_dst_addr_r,
    .dec_dest_file_r, .dec_bit_mask_r, .dec_ptr_sel_r, .dec_literal_r, .dec_lit_width_r,
    .dec_target_r, .dec_branch_rel_r, .dec_fast_r, .dec_cycles_r, .dec_may_skip_r,
    .tbl_addr_r, .tbl_rd_r, .tbl_wr_r, .tbl_wdata_r, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ofd_fetch_model ofd_fetch_model_i (.clk, .rst_n, .instr_word, .instr_valid, .tbl_addr_r,
    .tbl_rd_r, .tbl_rdata, .tbl_rdata_valid);
  ////////////////////////////////////////////////////////////////////
  // compare, bus cycles and decode wait
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    chk(s_axi_bvalid, 1'b1);
    chk(s_axi_bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    chk(s_axi_rvalid, 1'b1);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask
  task automatic dec(input logic [15:0] w0, input logic [15:0] w1, input bit two);
    int n = 0;
    ofd_fetch_model_i.push(w0);
    if (two) ofd_fetch_model_i.push(w1);
    do begin
      @(posedge clk);
      n++;
    end while (dec_valid_r !== 1'b1 && n < 40);
    chk(dec_valid_r, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    axr(ofd_pkg::ADR_CTRL, ofd_pkg::CTRL_RST, ofd_pkg::RESP_OKAY);
    axr(8'h14, 32'h0, ofd_pkg::RESP_SLVERR);
    axw(8'h14, 32'h1, ofd_pkg::RESP_SLVERR);
    axw(ofd_pkg::ADR_TPTR, 32'hffff_ffff, ofd_pkg::RESP_OKAY);
    axr(ofd_pkg::ADR_TPTR, 32'h001f_ffff, ofd_pkg::RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_byte();
    dec(16'h2a53, 16'h0, 0);
    chk(dec_src_addr_r, 12'h053);
    chk(dec_dest_file_r, 1'b1);
    chk(dec_cycles_r, ofd_pkg::CYC_ONE);
    axw(ofd_pkg::ADR_CTRL, 32'h0000_0105, ofd_pkg::RESP_OKAY);
    dec(16'h2b53, 16'h0, 0);
    chk(dec_src_addr_r, 12'h553);
    dec(16'h28a0, 16'h0, 0);
    chk(dec_src_addr_r, 12'hfa0);
    chk(dec_dest_file_r, 1'b0);
    for (int b = 0; b < 8; b++) begin
      dec(16'h8112 | 16'(b << 9), 16'h0, 0);
      chk(dec_bit_mask_r, 8'h01 << b);
      chk(dec_form_r, ofd_pkg::F_BIT);
    end
    $display("test byte done");
  endtask
  task automatic t_forms();
    dec(16'hc123, 16'hf456, 1);
    chk({dec_src_addr_r, dec_dst_addr_r}, 24'h123456);
    dec(16'hf456, 16'h0, 0);
    chk(dec_form_r, ofd_pkg::F_ORPHAN);
    dec(16'hffff, 16'h0, 0);
    chk(dec_form_r, ofd_pkg::F_ORPHAN);
    dec(16'hee25, 16'hf0ab, 1);
    chk({dec_ptr_sel_r, dec_literal_r, dec_lit_width_r}, {2'h2, 20'h005ab, ofd_pkg::LW_12});
    dec(16'h0e7f, 16'h0, 0);
    chk({dec_literal_r, dec_lit_width_r}, {20'h0007f, ofd_pkg::LW_8});
    dec(16'hef12, 16'hf345, 1);
    chk({dec_target_r, dec_branch_rel_r}, {20'h34512, 1'b0});
    chk(dec_cycles_r, ofd_pkg::CYC_TWO);
    dec(16'hd400, 16'h0, 0);
    chk({dec_target_r, dec_branch_rel_r}, {20'hffc00, 1'b1});
    dec(16'h0013, 16'h0, 0);
    chk({dec_form_r, dec_fast_r}, {ofd_pkg::F_RET, 1'b1});
    dec(16'h0012, 16'h0, 0);
    chk(dec_fast_r, 1'b0);
    dec(16'hed12, 16'hf000, 1);
    chk({dec_form_r, dec_fast_r, dec_target_r}, {ofd_pkg::F_CALL, 1'b1, 20'h00012});
    axw(ofd_pkg::ADR_IPTR, 32'h100, ofd_pkg::RESP_OKAY);
    dec(16'heb7f, 16'hf234, 1);
    chk({dec_src_addr_r, dec_dst_addr_r}, 24'h17f234);
    axr(ofd_pkg::ADR_STAT, 32'({ofd_pkg::F_IDX_SF, 1'b0}), ofd_pkg::RESP_OKAY);
    dec(16'he0fe, 16'h0, 0);
    chk({dec_target_r, dec_may_skip_r, dec_cycles_r}, {20'hffffe, 1'b1, ofd_pkg::CYC_ONE});
    dec(16'hc123, 16'h0456, 1);
    axr(ofd_pkg::ADR_STAT, 32'({1'b1, 2'h0, ofd_pkg::F_MOVFF, 1'b0}), ofd_pkg::RESP_OKAY);
    $display("test forms done");
  endtask
  task automatic t_table();
    logic [20:0] p = 21'h1f_ffff, a;
    axw(ofd_pkg::ADR_TPTR, 32'h001f_ffff, ofd_pkg::RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      if (m == 3) p = p + 21'h1;
      a = p;
      if (m == 1) p = p + 21'h1;
      if (m == 2) p = p - 21'h1;
      dec(16'h0008 | 16'(m), 16'h0, 0);
      chk({tbl_rd_r, tbl_addr_r}, {1'b1, a});
      axr(ofd_pkg::ADR_TPTR, 32'(p), ofd_pkg::RESP_OKAY);
      axr(ofd_pkg::ADR_TLAT, 32'(a[7:0] ^ 8'ha5), ofd_pkg::RESP_OKAY);
    end
    dec(16'h000c, 16'h0, 0);
    chk({tbl_rd_r, tbl_wr_r, tbl_addr_r, tbl_wdata_r}, {2'h1, p, a[7:0] ^ 8'ha5});
    $display("test table done");
  endtask
  ////////////////////////////////////////////////////////////////////
  // verdict, watchdog, main sequence
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #80000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_byte();
    t_forms();
    t_table();
    give_verdict();
  end
endmodule
`default_nettype wire
